//--- fdas_service.sv
// Purpose: explicit-request handler for diag extract, global control and alarm flags
// Assumes: host holds no request while busy and takes every reply byte
// Notes:   one request at a time; reply streamed a byte per cycle
//
// Summary of operation
// - diag extract 0x52 to 0x432/1, 6 bytes
// - no slave reply in time gives timeout status
// - mode 0 returns buffer, pending untouched
// - mode 1 returns buffer, clears pending
// - mode 2 polls slave, returns fresh bytes
// - reply: status, 0, count, 0, data
// - global control is 0x54, 6-byte body
// - one multicast frame to the named group
// - decode clear, freeze, unfreeze, sync, unsync codes
// - gc reply 0x00 sent, 0x13 failed
// - new alarm sets a host-visible flag
// - more queued alarms re-raise the pending bit
// - alarm pending vector, bit per station 0-126
// - per-slave alarm flag for a chosen station
// - diag pending vector, bit per station 0-126
`timescale 1ns/1ps
`default_nettype none
module fdas_service
  import fdas_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // host request and reply
  input  wire logic             req_valid_in,
  input  wire fdas_req_t        req_in,
  output logic                  busy_out,
  output fdas_rsp_t             rsp_out,
  // fieldbus diagnostics
  input  wire fdas_rx_t         diag_rx_in,
  output logic                  diag_poll_out,
  output logic [6:0]            diag_poll_station_out,
  // fieldbus global control
  output logic                  gc_send_out,
  output fdas_gc_t              gc_frame_out,
  input  wire logic             gc_done_in,
  input  wire logic             gc_fail_in,
  // fieldbus alarms
  input  wire logic             alarm_rx_valid_in,
  input  wire logic [6:0]       alarm_rx_station_in,
  input  wire logic             alarm_taken_in,
  input  wire logic [6:0]       alarm_taken_station_in,
  // status
  input  wire logic [6:0]       slave_sel_in,
  output logic                  slave_alarm_flag_out,
  output logic [NODES-1:0]      node_alarm_pending_vector_out,
  output logic [NODES-1:0]      node_diag_pending_vector_out
);
  typedef struct packed {
    fdas_state_t             st;
    fdas_req_t               req;
    logic                    busy;
    logic [6:0]              station;
    logic                    is_gc;
    logic                    short_rsp;
    logic [7:0]              status;
    logic [5:0]              cnt;
    logic [5:0]              idx;
    fdas_rsp_t               rsp;
    logic                    poll;
    logic                    tmr_start;
    logic                    gc_send;
    fdas_gc_t                gc;
    logic [5:0]              rx_idx;
    logic [NODES-1:0][5:0]   diag_len;
    logic [NODES-1:0]        diag_pend;
    logic [NODES-1:0][3:0]   alarm_cnt;
    logic [NODES-1:0]        alarm_pend;
    logic                    slave_flag;
  } fdas_core_t;

  fdas_core_t s;
  fdas_core_t next_s;

  logic       rx_hit;
  logic       rx_done;
  logic       tmr_exp;
  logic [7:0] mem_rdata;

  function automatic logic node_ok(input logic [7:0] a);
    return a < 8'(NODES);
  endfunction : node_ok

  function automatic logic req_ok(input fdas_req_t r);
    return r.cls == OBJ_CLASS && r.inst == OBJ_INST && r.len == BODY_LEN;
  endfunction : req_ok

  function automatic logic ctl_ok(input logic [7:0] c);
    return c[7:6] == 2'b00 && (c[3:0] == CTL_CLR_REL || c[3:0] == CTL_CLR ||
           c[3:0] == CTL_FRZ || c[3:0] == CTL_UFRZ_A || c[3:0] == CTL_UFRZ_B);
  endfunction : ctl_ok

  function automatic fdas_gc_t gc_decode(input logic [7:0] c, input logic [7:0] g);
    fdas_gc_t f;
    f.clear_release = (c[3:0] == CTL_CLR_REL);
    f.clear_force   = (c[3:0] == CTL_CLR);
    f.freeze        = (c[3:0] == CTL_FRZ);
    f.unfreeze      = (c[3:0] == CTL_UFRZ_A) || (c[3:0] == CTL_UFRZ_B);
    f.sync          = (c[5:4] == 2'b01);
    f.unsync        = c[5];
    f.group         = g;
    return f;
  endfunction : gc_decode

  //////////////////////////////////////////////////////////////////////////////
  assign rx_hit  = diag_rx_in.valid && node_ok({1'b0, diag_rx_in.station});
  assign rx_done = rx_hit && diag_rx_in.last;

  always_comb begin
    next_s           = s;
    next_s.rsp       = '0;
    next_s.poll      = 1'b0;
    next_s.gc_send   = 1'b0;
    next_s.tmr_start = 1'b0;
    // taking an alarm first, so one arriving in the same cycle still counts
    if (alarm_taken_in && node_ok({1'b0, alarm_taken_station_in})
        && s.alarm_cnt[alarm_taken_station_in] != 4'h0) begin
      next_s.alarm_cnt[alarm_taken_station_in] = s.alarm_cnt[alarm_taken_station_in] - 4'h1;
    end
    if (alarm_rx_valid_in && node_ok({1'b0, alarm_rx_station_in})
        && next_s.alarm_cnt[alarm_rx_station_in] != ALM_CNT_MAX) begin
      next_s.alarm_cnt[alarm_rx_station_in] = next_s.alarm_cnt[alarm_rx_station_in] + 4'h1;
    end
    for (int i = 0; i < NODES; i++) begin
      next_s.alarm_pend[i] = (next_s.alarm_cnt[i] != 4'h0);
    end
    next_s.slave_flag = node_ok({1'b0, slave_sel_in}) && next_s.alarm_pend[slave_sel_in];
    // one diag frame at a time on the bus; bytes past the slot are dropped
    if (rx_hit) begin
      if (s.rx_idx < DIAG_MAX) begin
        next_s.rx_idx = s.rx_idx + 6'h01;
      end
      if (diag_rx_in.last) begin
        next_s.rx_idx = 6'h00;
        next_s.diag_len[diag_rx_in.station] = (s.rx_idx < DIAG_MAX) ? s.rx_idx + 6'h01 : DIAG_MAX;
      end
    end
    case (s.st)
      S_IDLE: begin
        if (req_valid_in) begin
          next_s.req  = req_in;
          next_s.busy = 1'b1;
          next_s.st   = S_CHECK;
        end
      end
      S_CHECK: begin
        next_s.short_rsp = 1'b1;
        next_s.idx       = 6'h00;
        next_s.cnt       = 6'h00;
        next_s.st        = S_HDR;
        next_s.status    = ST_BAD_REQ;
        if (req_ok(s.req) && s.req.svc == SVC_DIAG && node_ok(s.req.b4)) begin
          next_s.station = s.req.b4[6:0];
          next_s.is_gc   = 1'b0;
          case (s.req.b5)
            MODE_BUF, MODE_BUF_CLR: begin
              next_s.short_rsp = 1'b0;
              next_s.status    = ST_OK;
              next_s.cnt       = s.diag_len[s.req.b4[6:0]];
              if (s.req.b5 == MODE_BUF_CLR) begin
                next_s.diag_pend[s.req.b4[6:0]] = 1'b0;
              end
            end
            MODE_POLL: begin
              next_s.poll      = 1'b1;
              next_s.tmr_start = 1'b1;
              next_s.st        = S_WAIT;
            end
            default: begin
              next_s.status = ST_BAD_MODE;
            end
          endcase
        end else if (req_ok(s.req) && s.req.svc == SVC_GC) begin
          next_s.status = ST_GC_FAIL;
          if (ctl_ok(s.req.b4)) begin
            next_s.gc        = gc_decode(s.req.b4, s.req.b5);
            next_s.gc_send   = 1'b1;
            next_s.tmr_start = 1'b1;
            next_s.is_gc     = 1'b1;
            next_s.st        = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (!s.is_gc && rx_done && diag_rx_in.station == s.station) begin
          next_s.status    = ST_OK;
          next_s.short_rsp = 1'b0;
          next_s.cnt       = next_s.diag_len[s.station];
          next_s.st        = S_HDR;
        end else if (s.is_gc && gc_done_in) begin
          next_s.status = gc_fail_in ? ST_GC_FAIL : ST_OK;
          next_s.st     = S_HDR;
        end else if (tmr_exp && !s.tmr_start) begin
          next_s.status    = ST_TIMEOUT;
          next_s.short_rsp = 1'b1;
          next_s.st        = S_HDR;
        end
      end
      S_HDR: begin
        next_s.rsp.valid = 1'b1;
        next_s.rsp.data  = (s.idx == 6'h00) ? s.status : (s.idx == 6'h02) ? {2'b00, s.cnt} : 8'h00;
        next_s.rsp.last  = s.short_rsp || (s.idx == HDR_LAST && s.cnt == 6'h00);
        if (next_s.rsp.last) begin
          next_s.st   = S_IDLE;
          next_s.busy = 1'b0;
        end else if (s.idx == HDR_LAST) begin
          next_s.idx = 6'h00;
          next_s.st  = S_DATA;
        end else begin
          next_s.idx = s.idx + 6'h01;
        end
      end
      S_DATA: begin
        next_s.rsp.valid = 1'b1;
        next_s.rsp.data  = mem_rdata;
        next_s.rsp.last  = (s.idx == s.cnt - 6'h01);
        next_s.idx       = s.idx + 6'h01;
        if (next_s.rsp.last) begin
          next_s.st   = S_IDLE;
          next_s.busy = 1'b0;
        end
      end
      default: begin
        next_s.st = S_IDLE;
      end
    endcase
    // a report landing with a mode-1 clear keeps its pending bit
    if (rx_done) begin
      next_s.diag_pend[diag_rx_in.station] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // a buffered reply can mix old and new bytes if the slave reports mid-reply
  fdas_diag_mem u_mem (
    .clk_in      (clk_in),
    .wr_en_in    (rx_hit && s.rx_idx < DIAG_MAX),
    .wr_addr_in  ({diag_rx_in.station, s.rx_idx[4:0]}),
    .wr_data_in  (diag_rx_in.data),
    .rd_addr_in  ({s.station, next_s.idx[4:0]}),
    .rd_data_out (mem_rdata)
  );

  fdas_ms_timer #(.CYC_MS(CYC_MS)) u_tmr (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .start_in    (s.tmr_start),
    .ms_in       (s.req.timeout_ms),
    .expired_out (tmr_exp)
  );

  assign busy_out                      = s.busy;
  assign rsp_out                       = s.rsp;
  assign diag_poll_out                 = s.poll;
  assign diag_poll_station_out         = s.station;
  assign gc_send_out                   = s.gc_send;
  assign gc_frame_out                  = s.gc;
  assign slave_alarm_flag_out          = s.slave_flag;
  assign node_alarm_pending_vector_out = s.alarm_pend;
  assign node_diag_pending_vector_out  = s.diag_pend;

  //////////////////////////////////////////////////////////////////////////////
  a_poll_sent:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.st == S_CHECK && req_ok(s.req) && s.req.svc == SVC_DIAG && node_ok(s.req.b4)
     && s.req.b5 == MODE_POLL) |=> (diag_poll_out && diag_poll_station_out == $past(s.req.b4[6:0])))
    else $error("mode 2 did not poll the slave");

  a_bad_mode_quiet:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.st == S_CHECK && req_ok(s.req) && s.req.svc == SVC_DIAG && node_ok(s.req.b4)
     && s.req.b5 > MODE_POLL) |=> !diag_poll_out ##1 (rsp_out.valid && rsp_out.last && rsp_out.data == ST_BAD_MODE))
    else $error("bad mode not rejected cleanly");

  a_mode1_clears:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.st == S_CHECK && req_ok(s.req) && s.req.svc == SVC_DIAG && node_ok(s.req.b4)
     && s.req.b5 == MODE_BUF_CLR && !rx_done) |=> !node_diag_pending_vector_out[$past(s.req.b4[6:0])])
    else $error("mode 1 left diag pending set");

  a_mode0_keeps:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.st == S_CHECK && s.req.svc == SVC_DIAG && s.req.b5 == MODE_BUF && !rx_done)
    |=> $stable(node_diag_pending_vector_out))
    else $error("mode 0 changed diag pending");

  a_gc_single_frame:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    gc_send_out |=> (!gc_send_out && busy_out && $stable(gc_frame_out)))
    else $error("global control sent more than one frame");

  a_gc_status_code:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.st == S_WAIT && s.is_gc && gc_done_in)
    |-> ##2 (rsp_out.valid && rsp_out.last && rsp_out.data == ($past(gc_fail_in, 2) ? ST_GC_FAIL : ST_OK)))
    else $error("global control status wrong");

  a_timeout_reply:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.st == S_WAIT && tmr_exp && !s.tmr_start && !(s.is_gc && gc_done_in)
     && !(!s.is_gc && rx_done && diag_rx_in.station == s.station))
    |-> ##2 (rsp_out.valid && rsp_out.data == ST_TIMEOUT && rsp_out.last))
    else $error("timeout not answered");

  a_alarm_flagged:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (alarm_rx_valid_in && node_ok({1'b0, alarm_rx_station_in}))
    |=> node_alarm_pending_vector_out[$past(alarm_rx_station_in)])
    else $error("new alarm not flagged");

  a_alarm_requeue:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (alarm_taken_in && node_ok({1'b0, alarm_taken_station_in}) && s.alarm_cnt[alarm_taken_station_in] > 4'h1)
    |=> node_alarm_pending_vector_out[$past(alarm_taken_station_in)])
    else $error("queued alarm not re-raised");

  a_one_reply:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rsp_out.valid && rsp_out.last) |-> (!busy_out && s.st == S_IDLE && !$past(rsp_out.last)))
    else $error("reply end and busy disagree");
endmodule : fdas_service
`default_nettype wire

//--- fdas_pkg.sv
// Purpose: shared constants and carriers of the fieldbus diag/alarm service handler
// Assumes: 10 MHz clock, host hands a whole request as one word
// Notes:   status codes other than success and gc-failure are local choices
package fdas_pkg;
  // request recognition
  localparam logic [7:0]  SVC_DIAG     = 8'h52;
  localparam logic [7:0]  SVC_GC       = 8'h54;
  localparam logic [15:0] OBJ_CLASS    = 16'h0432;
  localparam logic [7:0]  OBJ_INST     = 8'h01;
  localparam logic [7:0]  BODY_LEN     = 8'h06;
  // extraction modes
  localparam logic [7:0]  MODE_BUF     = 8'h00;
  localparam logic [7:0]  MODE_BUF_CLR = 8'h01;
  localparam logic [7:0]  MODE_POLL    = 8'h02;
  // reply status
  localparam logic [7:0]  ST_OK        = 8'h00;
  localparam logic [7:0]  ST_GC_FAIL   = 8'h13;
  localparam logic [7:0]  ST_TIMEOUT   = 8'h02;
  localparam logic [7:0]  ST_BAD_MODE  = 8'h03;
  localparam logic [7:0]  ST_BAD_REQ   = 8'h08;
  // global control byte
  localparam logic [3:0]  CTL_CLR_REL  = 4'h0;
  localparam logic [3:0]  CTL_CLR      = 4'h2;
  localparam logic [3:0]  CTL_FRZ      = 4'h4;
  localparam logic [3:0]  CTL_UFRZ_A   = 4'h8;
  localparam logic [3:0]  CTL_UFRZ_B   = 4'hC;
  // sizes
  localparam int          NODES        = 127;
  localparam logic [5:0]  DIAG_MAX     = 6'h20;
  localparam logic [5:0]  HDR_LAST     = 6'h03;
  localparam logic [3:0]  ALM_CNT_MAX  = 4'hF;
  localparam int          MEM_AW       = 12;
  // timing
  localparam int          MS_NS        = 1000000;
  localparam int          CLK_NS       = 100;
  localparam int          CYC_PER_MS   = MS_NS / CLK_NS;

  typedef struct packed {
    logic [7:0]  svc;
    logic [15:0] cls;
    logic [7:0]  inst;
    logic [7:0]  len;
    logic [31:0] timeout_ms;
    logic [7:0]  b4;
    logic [7:0]  b5;
  } fdas_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } fdas_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] station;
    logic [7:0] data;
    logic       last;
  } fdas_rx_t;

  typedef struct packed {
    logic       clear_release;
    logic       clear_force;
    logic       freeze;
    logic       unfreeze;
    logic       sync;
    logic       unsync;
    logic [7:0] group;
  } fdas_gc_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CHECK = 3'b001,
    S_WAIT  = 3'b011,
    S_HDR   = 3'b010,
    S_DATA  = 3'b110
  } fdas_state_t;
endpackage : fdas_pkg

//--- fdas_diag_mem.sv
// Purpose: diagnostic byte store, one 32-byte slot per station
// Assumes: one write and one read port, read data registered
// Notes:   contents are undefined until a station first reports
`timescale 1ns/1ps
`default_nettype none
module fdas_diag_mem
  import fdas_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // write side
  input  wire logic              wr_en_in,
  input  wire logic [MEM_AW-1:0] wr_addr_in,
  input  wire logic [7:0]        wr_data_in,
  // read side
  input  wire logic [MEM_AW-1:0] rd_addr_in,
  output var  logic [7:0]        rd_data_out
);
  logic [7:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule : fdas_diag_mem
`default_nettype wire

//--- fdas_ms_timer.sv
// Purpose: millisecond timeout for a pending fieldbus exchange
// Assumes: start is a one-cycle pulse carrying the timeout
// Notes:   zero milliseconds expires at once
`timescale 1ns/1ps
`default_nettype none
module fdas_ms_timer
  import fdas_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // control
  input  wire logic        start_in,
  input  wire logic [31:0] ms_in,
  output logic             expired_out
);
  typedef struct packed {
    logic [31:0] pre;
    logic [31:0] ms_left;
    logic        expired;
  } fdas_tmr_t;

  fdas_tmr_t s;
  fdas_tmr_t next_s;

  always_comb begin
    next_s = s;
    if (start_in) begin
      next_s.pre     = 32'h0000_0000;
      next_s.ms_left = ms_in;
      next_s.expired = (ms_in == 32'h0000_0000);
    end else if (!s.expired) begin
      if (s.pre == 32'(CYC_MS - 1)) begin
        next_s.pre     = 32'h0000_0000;
        next_s.ms_left = s.ms_left - 32'h0000_0001;
        next_s.expired = (s.ms_left == 32'h0000_0001);
      end else begin
        next_s.pre = s.pre + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expired_out = s.expired;
endmodule : fdas_ms_timer
`default_nettype wire

//--- fdas_slave_model.sv
// Purpose: fieldbus slave side of the service handler bench
// Assumes: one diag frame in flight at a time; outputs change 2 ns after the edge
// Notes:   idle lines carry a moving pattern so a stale byte never looks like a live one
`timescale 1ns/1ps
`default_nettype none
module fdas_slave_model
  import fdas_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // design side
  input  wire logic       diag_poll_in,
  input  wire logic [6:0] poll_station_in,
  input  wire logic       gc_send_in,
  output var  fdas_rx_t   diag_rx_out,
  output var  logic       gc_done_out,
  output var  logic       gc_fail_out,
  // bench control
  input  wire logic       push_in,
  input  wire logic [6:0] push_station_in,
  input  wire logic [7:0] delay_in,
  input  wire logic [5:0] nbytes_in,
  input  wire logic       silent_in,
  input  wire logic       gc_fail_mode_in
);
  logic       act;
  logic       gact;
  logic       fresh;
  logic [7:0] dly;
  logic [7:0] gdly;
  logic [7:0] ptn;
  logic [6:0] st;
  logic [5:0] k;
  fdas_rx_t   rx_n;
  logic       done_n;
  logic       fail_n;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    act = 1'b0;
    gact = 1'b0;
    ptn = 8'h00;
    diag_rx_out = '0;
    gc_done_out = 1'b0;
    gc_fail_out = 1'b0;
  end
  always @(posedge clk_in) begin
    #2;
    ptn = ptn + 8'h3B;
    rx_n = '{1'b0, ptn[6:0], ~ptn, 1'b0};
    done_n = 1'b0;
    fail_n = ptn[0];
    if (!rst_n_in) begin
      act = 1'b0;
      gact = 1'b0;
    end
    // a silent slave never answers the poll, so the wait must time out
    if (diag_poll_in && !silent_in) begin
      act = 1'b1;
      st = poll_station_in;
      fresh = 1'b1;
      dly = delay_in;
      k = 6'h00;
    end
    if (push_in) begin
      act = 1'b1;
      st = push_station_in;
      fresh = 1'b0;
      dly = 8'h00;
      k = 6'h00;
    end
    if (gc_send_in) begin
      gact = 1'b1;
      gdly = delay_in;
    end
    if (act && dly != 8'h00) begin
      dly = dly - 8'h01;
    end else if (act) begin
      rx_n = '{1'b1, st, ({1'b0, st} + {2'b00, k}) ^ {8{fresh}}, k == nbytes_in - 6'h01};
      k = k + 6'h01;
      act = (k != nbytes_in);
    end
    if (gact && gdly != 8'h00) begin
      gdly = gdly - 8'h01;
    end else if (gact) begin
      done_n = 1'b1;
      fail_n = gc_fail_mode_in;
      gact = 1'b0;
    end
    // one update per edge, so the design never sees a passing value
    diag_rx_out = rx_n;
    gc_done_out = done_n;
    gc_fail_out = fail_n;
  end
endmodule : fdas_slave_model
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench of the diag, global control and alarm services
// Assumes: CYC_MS shortened to 4 cycles per ms
// Notes:   requests are driven 1 ns after the edge, replies sampled there too
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fdas_pkg::*;
;
  localparam int CYC = 4;
  logic clk_in, rst_n_in, req_valid_in, busy_out, diag_poll, gc_send, gc_done, gc_fail;
  logic alm_rx, alm_tk, slave_flag, push, silent, gfail;
  logic [6:0] poll_st_o, alm_st, slave_sel, push_st, poll_st;
  logic [7:0] dly;
  logic [5:0] nb;
  logic [NODES-1:0] alarm_vec, diag_vec;
  fdas_req_t req_in;
  fdas_rsp_t rsp_out;
  fdas_rx_t diag_rx;
  fdas_gc_t gc_frame, gc_seen;
  logic [7:0] rsp_q[$], exp_q[$], codes[8];
  int rsp_cyc, polls, gcs, cyc, failures, samples_checked;
  ////////////////////////////////////////////////////////////////////////////
  fdas_service #(.CYC_MS(CYC)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .busy_out(busy_out), .rsp_out(rsp_out), .diag_rx_in(diag_rx), .diag_poll_out(diag_poll),
    .diag_poll_station_out(poll_st_o), .gc_send_out(gc_send), .gc_frame_out(gc_frame), .gc_done_in(gc_done),
    .gc_fail_in(gc_fail), .alarm_rx_valid_in(alm_rx), .alarm_rx_station_in(alm_st), .alarm_taken_in(alm_tk),
    .alarm_taken_station_in(alm_st), .slave_sel_in(slave_sel), .slave_alarm_flag_out(slave_flag),
    .node_alarm_pending_vector_out(alarm_vec), .node_diag_pending_vector_out(diag_vec));
  fdas_slave_model u_slave (.clk_in(clk_in), .rst_n_in(rst_n_in), .diag_poll_in(diag_poll),
    .poll_station_in(poll_st_o), .gc_send_in(gc_send), .diag_rx_out(diag_rx), .gc_done_out(gc_done),
    .gc_fail_out(gc_fail), .push_in(push), .push_station_in(push_st), .delay_in(dly), .nbytes_in(nb),
    .silent_in(silent), .gc_fail_mode_in(gfail));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    #3;
    if (diag_poll === 1'b1) begin
      polls++;
      poll_st = poll_st_o;
    end
    if (gc_send === 1'b1) begin
      gcs++;
      gc_seen = gc_frame;
    end
  end
  // a hung handshake would otherwise stall the run forever
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic do_req(input logic [7:0] svc, input logic [15:0] cls, input logic [7:0] inst, input logic [7:0] len,
                        input logic [31:0] tmo, input logic [7:0] b4, input logic [7:0] b5);
    req_in = '{svc, cls, inst, len, tmo, b4, b5};
    req_valid_in = 1'b1;
    @(posedge clk_in);
    #1 req_valid_in = 1'b0;
    chk("busy_taken", 1'b1, busy_out);
    rsp_q.delete();
    for (int n = 0; n < 400; n++) begin
      if (rsp_out.valid === 1'b1) begin
        rsp_q.push_back(rsp_out.data);
        if (rsp_q.size() == 1) rsp_cyc = n;
        if (rsp_out.last === 1'b1) break;
      end
      @(posedge clk_in);
      #1;
    end
    chk("last_seen", 1'b1, rsp_out.last);
    chk("busy_done", 1'b0, busy_out);
  endtask : do_req
  task automatic chk_rsp();
    chk("rsp_len", exp_q.size(), rsp_q.size());
    foreach (exp_q[i]) chk("rsp_byte", exp_q[i], (i < rsp_q.size()) ? rsp_q[i] : 8'hXX);
  endtask : chk_rsp
  task automatic exp_diag(input logic [6:0] st, input logic [5:0] n, input logic fr);
    exp_q = '{ST_OK, 8'h00, {2'b00, n}, 8'h00};
    for (int k = 0; k < n; k++) exp_q.push_back(({1'b0, st} + 8'(k)) ^ {8{fr}});
    chk_rsp();
  endtask : exp_diag
  task automatic exp_one(input logic [7:0] b);
    exp_q = '{b};
    chk_rsp();
  endtask : exp_one
  task automatic alarm(input logic rx, input logic tk, input logic [6:0] s);
    alm_rx = rx;
    alm_tk = tk;
    alm_st = s;
    @(posedge clk_in);
    #1 alm_rx = 1'b0;
    alm_tk = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : alarm
  function automatic fdas_gc_t exp_gc(input logic [7:0] c, input logic [7:0] g);
    exp_gc = '{c[3:0] == 4'h0, c[3:0] == 4'h2, c[3:0] == 4'h4, c[3:0] == 4'h8 || c[3:0] == 4'hC,
               c[5:4] == 2'b01, c[5], g};
  endfunction : exp_gc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_in, req_valid_in, alm_rx, alm_tk, push, silent, gfail} = '0;
    {alm_st, slave_sel, push_st, dly, nb, req_in} = '0;
    codes = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h22, 8'h38};
    repeat (12) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    chk("alarm_vec_rst", 0, alarm_vec);
    chk("diag_vec_rst", 0, diag_vec);
    push_st = 7'h05;
    nb = 6'h03;
    push = 1'b1;
    @(posedge clk_in);
    #1 push = 1'b0;
    repeat (6) @(posedge clk_in);
    #1 chk("diag_pend_set", 1'b1, diag_vec[5]);
    do_req(SVC_DIAG, OBJ_CLASS, OBJ_INST, BODY_LEN, 20, 8'h05, MODE_BUF);
    exp_diag(7'h05, 6'h03, 1'b0);
    chk("diag_pend_keep", 1'b1, diag_vec[5]);
    do_req(SVC_DIAG, OBJ_CLASS, OBJ_INST, BODY_LEN, 20, 8'h05, MODE_BUF_CLR);
    exp_diag(7'h05, 6'h03, 1'b0);
    chk("diag_pend_clr", 1'b0, diag_vec[5]);
    chk("no_poll_buf", 0, polls);
    dly = 8'h03;
    nb = 6'h04;
    do_req(SVC_DIAG, OBJ_CLASS, OBJ_INST, BODY_LEN, 20, 8'h09, MODE_POLL);
    exp_diag(7'h09, 6'h04, 1'b1);
    chk("poll_count", 1, polls);
    chk("poll_station", 7'h09, poll_st);
    silent = 1'b1;
    do_req(SVC_DIAG, OBJ_CLASS, OBJ_INST, BODY_LEN, 2, 8'h09, MODE_POLL);
    exp_one(ST_TIMEOUT);
    chk("tmo_wait", 1'b1, rsp_cyc >= 2 * CYC && rsp_cyc <= 2 * CYC + 8);
    silent = 1'b0;
    do_req(SVC_DIAG, OBJ_CLASS, OBJ_INST, BODY_LEN, 20, 8'h09, 8'h03);
    exp_one(ST_BAD_MODE);
    chk("no_poll_bad", 2, polls);
    for (int i = 0; i < 5; i++) begin
      do_req((i == 0) ? 8'h53 : SVC_DIAG, (i == 1) ? 16'h0433 : OBJ_CLASS, (i == 2) ? 8'h02 : OBJ_INST,
             (i == 3) ? 8'h05 : BODY_LEN, 20, (i == 4) ? 8'h7F : 8'h05, MODE_BUF);
      exp_one(ST_BAD_REQ);
    end
    for (int i = 0; i < 8; i++) begin
      do_req(SVC_GC, OBJ_CLASS, OBJ_INST, BODY_LEN, 20, codes[i], 8'h40 + 8'(i));
      exp_one(ST_OK);
      chk("gc_frames", i + 1, gcs);
      chk("gc_frame", exp_gc(codes[i], 8'h40 + 8'(i)), gc_seen);
    end
    gfail = 1'b1;
    do_req(SVC_GC, OBJ_CLASS, OBJ_INST, BODY_LEN, 20, 8'h04, 8'h01);
    exp_one(ST_GC_FAIL);
    gfail = 1'b0;
    do_req(SVC_GC, OBJ_CLASS, OBJ_INST, BODY_LEN, 20, 8'h06, 8'h01);
    exp_one(ST_GC_FAIL);
    chk("gc_no_frame", 9, gcs);
    chk("gc_no_poll", 2, polls);
    slave_sel = 7'h07;
    alarm(1'b1, 1'b0, 7'h07);
    alarm(1'b1, 1'b0, 7'h07);
    alarm(1'b1, 1'b0, 7'h7E);
    chk("alarm_vec_set", {1'b1, 118'h0, 1'b1, 7'h00}, alarm_vec);
    chk("slave_flag_set", 1'b1, slave_flag);
    alarm(1'b0, 1'b1, 7'h07);
    chk("alarm_reraise", 1'b1, alarm_vec[7]);
    alarm(1'b0, 1'b1, 7'h07);
    chk("alarm_clear", 1'b0, alarm_vec[7]);
    chk("slave_flag_clr", 1'b0, slave_flag);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
